// file: bench/pmmc_asserts.sv
`timescale 1ns/10ps
module pmmc_asserts
	import pmmc_pkg::*;
#(
	parameter int START_DLY = PMMC_START_DLY
)(
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        SYS_RST,
	// Bus and events
	input wire logic [3:0]  AVS_ADDRESS,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        SLEEP_EXEC,
	input wire logic        WAKE_IRQ,
	input wire logic        WAKE_WDT,
	input wire logic        WDT_EN,
	// Clock outputs
	input wire pmmc_gate_t  GATES,
	input wire pmmc_flags_t FLAGS,
	input wire pmmc_clk_t   CLK_SRC
);
	localparam int WAKE_LIM = START_DLY + 24;
	logic [8:0] ctrl_r;
	//----------------------------------------------------------------
	// Control shadow and properties
	//----------------------------------------------------------------
	// Shadow of the control word, taken when the write is answered
	always_ff @(posedge MCLK)
		if (SYS_RST)
			ctrl_r <= 9'h000;
		else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0)
			ctrl_r <= AVS_WRITEDATA[8:0];
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	// Four steady cycles cover the two-cycle flag lag
	a_int_flag: assert property ((CLK_SRC == PMMC_CLK_INT && GATES.per_clk_en)[*4] |->
		!FLAGS.primary_clock_active_flag) else $error("primary flag on internal clock");
	a_pri_flag: assert property ((CLK_SRC == PMMC_CLK_PRI && GATES.per_clk_en)[*4] |->
		FLAGS.primary_clock_active_flag) else $error("primary flag missing");
	a_sec_flags: assert property ((CLK_SRC == PMMC_CLK_SEC && GATES.per_clk_en)[*4] |->
		FLAGS == 3'h1) else $error("secondary flags wrong");
	a_slow_kept: assert property (WDT_EN && $past(WDT_EN) |-> GATES.slow_osc_en)
		else $error("slow oscillator stopped");
	a_sleep_gate: assert property (SLEEP_EXEC && !ctrl_r[2] |-> ##[1:4]
		!GATES.cpu_clk_en && !GATES.per_clk_en && FLAGS == 3'h0) else $error("sleep not entered");
	a_idle_cpu: assert property (SLEEP_EXEC && ctrl_r[2] && ctrl_r[1:0] != 2'h1 |-> ##[1:4]
		!GATES.cpu_clk_en && GATES.per_clk_en) else $error("idle gating wrong");
	a_idle_flags: assert property (SLEEP_EXEC && ctrl_r[2:0] == 3'h4 && FLAGS == 3'h4 |=>
		$stable(FLAGS)[*4]) else $error("flags moved in primary idle");
	a_sec_refuse: assert property (SLEEP_EXEC && ctrl_r[2:0] == 3'h5 && !ctrl_r[8] &&
		GATES.cpu_clk_en |=> GATES.cpu_clk_en[*4]) else $error("refused sleep taken");
	a_wake_delay: assert property ((WAKE_IRQ || WAKE_WDT) && !GATES.cpu_clk_en &&
		GATES.per_clk_en |=> !GATES.cpu_clk_en[*3]) else $error("cpu started early");
	a_wake_resume: assert property ((WAKE_IRQ || WAKE_WDT) && !GATES.cpu_clk_en &&
		GATES.per_clk_en |-> ##[1:WAKE_LIM] GATES.cpu_clk_en) else $error("cpu not resumed");
	// Main scenarios reached
	c_sleep: cover property (SLEEP_EXEC && !ctrl_r[2]);
	c_secondary_idle: cover property (CLK_SRC == PMMC_CLK_SEC && !GATES.cpu_clk_en);
	c_settle: cover property ($rose(FLAGS.int_osc_stable_flag));
endmodule

bind pmmc_top pmmc_asserts #(.START_DLY(START_DLY)) i_pmmc_asserts (.MCLK(MCLK),
	.SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.SLEEP_EXEC(SLEEP_EXEC), .WAKE_IRQ(WAKE_IRQ), .WAKE_WDT(WAKE_WDT), .WDT_EN(WDT_EN),
	.GATES(GATES), .FLAGS(FLAGS), .CLK_SRC(CLK_SRC));

// file: bench/pmmc_osc_model.sv
`timescale 1ns/10ps
module pmmc_osc_model
	import pmmc_pkg::*;
#(
	parameter int PRI_START = 6
)(
	// Clock and oscillator enables
	input wire logic       MCLK,
	input wire pmmc_gate_t GATES,
	// Oscillator status
	output logic           PRI_READY,
	output logic           SEC_RUNNING,
	output logic           FAST_TICK,
	output logic           OLD_TICK
);
	int pri_cnt = 0;
	int sec_cnt = 0;
	initial {PRI_READY, SEC_RUNNING, FAST_TICK, OLD_TICK} = 4'h0;
	// Oscillators report ready only after a run of enabled cycles, never at once
	always @(posedge MCLK)
	begin
		pri_cnt <= GATES.pri_osc_en ? pri_cnt + 1 : 0;
		sec_cnt <= GATES.sec_osc_on ? sec_cnt + 1 : 0;
		PRI_READY <= pri_cnt >= PRI_START;
		SEC_RUNNING <= sec_cnt >= 3;
		FAST_TICK <= GATES.fast_osc_en && !FAST_TICK;
		OLD_TICK <= !OLD_TICK;
	end
endmodule

// file: bench/test_power_managed_mode_control.sv
`timescale 1ns/10ps
module test_power_managed_mode_control
	import pmmc_pkg::*;
;
	typedef struct packed {logic [8:0] ctrl; pmmc_clk_t src; logic [2:0] flg;} pmmc_row_t;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic        wait_req;
	logic        sleep_x = 1'b0;
	logic        wake_irq = 1'b0;
	logic        wake_wdt = 1'b0;
	logic        wdt_en = 1'b1;
	logic        staged_en = 1'b0;
	logic        pri_rdy, secondary_run, fast_tk, old_tk;
	pmmc_gate_t  gates;
	pmmc_flags_t flags;
	pmmc_clk_t   src;
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          n;
	// Control word, then the source and flags it should settle to
	pmmc_row_t rows [6] = '{'{9'h003, PMMC_CLK_INT, 3'h0}, '{9'h032, PMMC_CLK_INT, 3'h2},
		'{9'h000, PMMC_CLK_PRI, 3'h4}, '{9'h082, PMMC_CLK_INT, 3'h2},
		'{9'h101, PMMC_CLK_SEC, 3'h1}, '{9'h000, PMMC_CLK_PRI, 3'h4}};
	always #25 mclk = ~mclk;
	pmmc_top #(.START_DLY(4), .SETTLE_DLY(4)) i_pmmc_top (.MCLK(mclk), .SYS_RST(sys_rst),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.SLEEP_EXEC(sleep_x), .WAKE_IRQ(wake_irq), .WAKE_WDT(wake_wdt), .PRI_READY(pri_rdy),
		.SEC_RUNNING(secondary_run), .FAST_TICK(fast_tk), .OLD_TICK(old_tk), .WDT_EN(wdt_en),
		.FSCM_EN(1'b0), .STAGED_EN(staged_en), .GATES(gates), .FLAGS(flags), .CLK_SRC(src));
	pmmc_osc_model i_pmmc_osc_model (.MCLK(mclk), .GATES(gates), .PRI_READY(pri_rdy),
		.SEC_RUNNING(secondary_run), .FAST_TICK(fast_tk), .OLD_TICK(old_tk));
	//----------------------------------------------------------------
	// Shared tasks
	//----------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus cycle held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		do @(posedge mclk); while (wait_req !== 1'b0 && ++k < 20);
		chk(wait_req, 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// One-cycle event strobe: 0 sleep, 1 interrupt wake, 2 watchdog wake
	task pulse(input int w);
		@(posedge mclk);
		sleep_x <= (w == 0);
		wake_irq <= (w == 1);
		wake_wdt <= (w == 2);
		@(posedge mclk);
		{sleep_x, wake_irq, wake_wdt} <= 3'h0;
	endtask
	// Bounded wait for the source switch to finish
	task settle(input pmmc_clk_t s, input logic [2:0] f);
		n = 0;
		while ((src !== s || flags !== f) && n < 300)
		begin
			@(posedge mclk);
			n++;
		end
		chk(src, s);
		chk(flags, f);
	endtask
	task wait_cpu;
		n = 0;
		while (gates.cpu_clk_en !== 1'b1 && n < 100)
		begin
			@(posedge mclk);
			n++;
		end
		chk(n >= 3 && n < 100, 1'b1);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			test_done;
		end
	end
	//----------------------------------------------------------------
	// Main sequence
	//----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge mclk);
		chk({gates.cpu_clk_en, gates.per_clk_en, flags}, 5'h18);
		sys_rst <= 1'b0;
		settle(PMMC_CLK_PRI, 3'h4);
		$display("reset test done");
		foreach (rows[i])
		begin
			bus(1'b1, 4'h0, {23'h0, rows[i].ctrl});
			settle(rows[i].src, rows[i].flg);
			bus(1'b0, 4'h0, 32'h0);
			chk(q[8:0], rows[i].ctrl);
		end
		bus(1'b0, 4'h5, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 4'h1, 32'h0);
		chk(q[4:0], {PMMC_CLK_PRI, 3'h4});
		$display("table test done");
		// Second pass: watchdog off, staged start-up wakes on the internal source
		for (int j = 0; j < 2; j++)
		begin
			repeat (8) @(posedge mclk);
			wdt_en <= (j == 0);
			staged_en <= (j == 1);
			pulse(0);
			repeat (5) @(posedge mclk);
			chk({gates.cpu_clk_en, gates.per_clk_en, flags}, 5'h0);
			chk(gates.slow_osc_en, j == 0);
			pulse(1);
			if (j == 1)
				settle(PMMC_CLK_INT, 3'h0);
			settle(PMMC_CLK_PRI, 3'h4);
		end
		wdt_en <= 1'b1;
		staged_en <= 1'b0;
		$display("sleep test done");
		bus(1'b1, 4'h0, 32'h4);
		for (int j = 0; j < 2; j++)
		begin
			pulse(0);
			repeat (5) @(posedge mclk);
			chk({gates.cpu_clk_en, gates.per_clk_en, gates.pri_osc_en, flags}, 6'h1C);
			pulse(j + 1);
			wait_cpu();
		end
		$display("primary idle test done");
		bus(1'b1, 4'h0, 32'h5);
		pulse(0);
		repeat (5) @(posedge mclk);
		chk(gates.cpu_clk_en, 1'b1);
		bus(1'b1, 4'h0, 32'h105);
		settle(PMMC_CLK_SEC, 3'h1);
		pulse(0);
		repeat (5) @(posedge mclk);
		chk({gates.cpu_clk_en, gates.per_clk_en, gates.pri_osc_en, flags}, 6'h11);
		pulse(1);
		wait_cpu();
		settle(PMMC_CLK_SEC, 3'h1);
		$display("secondary idle test done");
		// Reset again in mid-run, taken while on the secondary source
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({gates.cpu_clk_en, gates.per_clk_en, flags, src}, {5'h18, PMMC_CLK_PRI});
		sys_rst <= 1'b0;
		settle(PMMC_CLK_PRI, 3'h4);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h0);
		$display("second reset test done");
		test_done;
	end
endmodule

// file: design/pmmc_pkg.sv
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
package pmmc_pkg;
	// Clock source select codes
	localparam logic [1:0] PMMC_SRC_PRI     = 2'h0;
	localparam logic [1:0] PMMC_SRC_SEC     = 2'h1;
	localparam int         PMMC_SRC_HI_BIT  = 1;
	localparam int         PMMC_FREQ_W      = 3;
	// Timing counts in cycles of the source clocks (sampled as edges), PMMC_START_DLY in MCLK cycles
	localparam int         PMMC_OLD_CYC     = 2;
	localparam int         PMMC_NEW_CYC     = 3;
	localparam int         PMMC_START_DLY   = 16;
	localparam int         PMMC_SETTLE_DLY  = 64;
	localparam int         PMMC_CNT_W       = 16;

	// Current device clock source
	typedef enum logic [1:0] {PMMC_CLK_NONE, PMMC_CLK_PRI, PMMC_CLK_SEC, PMMC_CLK_INT}
		pmmc_clk_t;

	// Clock gate and oscillator enables
	typedef struct packed {
		logic cpu_clk_en;
		logic per_clk_en;
		logic pri_osc_en;
		logic sec_osc_on;
		logic fast_osc_en;
		logic slow_osc_en;
	} pmmc_gate_t;

	// Status flags
	typedef struct packed {
		logic primary_clock_active_flag;
		logic int_osc_stable_flag;
		logic secondary_clock_active_flag;
	} pmmc_flags_t;
endpackage

// file: design/pmmc_top.sv
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module pmmc_top
	import pmmc_pkg::*;
#(
	parameter int START_DLY  = PMMC_START_DLY,    // Cycle counts, not times
	parameter int SETTLE_DLY = PMMC_SETTLE_DLY
)(
	// Clock and reset
	input  wire logic                   MCLK,
	input  wire logic                   SYS_RST,
	// Avalon-MM slave
	input  wire logic [3:0]             AVS_ADDRESS,
	input  wire logic                   AVS_READ,
	input  wire logic                   AVS_WRITE,
	input  wire logic [31:0]            AVS_WRITEDATA,
	input  wire logic [3:0]             AVS_BYTEENABLE,
	output logic      [31:0]            AVS_READDATA,
	output logic                        AVS_WAITREQUEST,
	// Core events
	input  wire logic                   SLEEP_EXEC,
	input  wire logic                   WAKE_IRQ,
	input  wire logic                   WAKE_WDT,
	// Oscillator status and strap options
	input  wire logic                   PRI_READY,
	input  wire logic                   SEC_RUNNING,
	input  wire logic                   FAST_TICK,
	input  wire logic                   OLD_TICK,
	input  wire logic                   WDT_EN,
	input  wire logic                   FSCM_EN,
	input  wire logic                   STAGED_EN,
	// Gated clock enables and status
	output pmmc_gate_t                  GATES,
	output pmmc_flags_t                 FLAGS,
	output pmmc_clk_t                   CLK_SRC
);
	//--------------------------------------------------------------
	// Register map
	//--------------------------------------------------------------
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_STAT = 4'h1;

	logic [1:0]             clk_source_select_r;
	logic                   idle_on_sleep_r;
	logic [PMMC_FREQ_W-1:0] int_freq_select_r;
	logic                   int_low_src_select_r;
	logic                   secondary_osc_enable_r;
	logic                   wait_r;

	function automatic pmmc_clk_t sel_src(input logic [1:0] s);
		if (s[PMMC_SRC_HI_BIT])
			sel_src = PMMC_CLK_INT;    // Low bit ignored
		else if (s == PMMC_SRC_SEC)
			sel_src = PMMC_CLK_SEC;
		else
			sel_src = PMMC_CLK_PRI;
	endfunction

	// One wait cycle on every access keeps the answer registered
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			wait_r <= 1'b0;
		else
			wait_r <= (AVS_READ | AVS_WRITE) & ~wait_r;
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			AVS_WAITREQUEST <= 1'b1;
		else
			AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~wait_r);
	end

	// Control writes; the block never writes these itself
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			clk_source_select_r    <= 2'h0;
			idle_on_sleep_r        <= 1'b0;
			int_freq_select_r      <= '0;
			int_low_src_select_r   <= 1'b0;
			secondary_osc_enable_r <= 1'b0;
		end
		else if (AVS_WRITE && wait_r && AVS_ADDRESS == A_CTRL && AVS_BYTEENABLE[0])
		begin
			clk_source_select_r    <= AVS_WRITEDATA[1:0];
			idle_on_sleep_r        <= AVS_WRITEDATA[2];
			int_freq_select_r      <= AVS_WRITEDATA[6:4];
			int_low_src_select_r   <= AVS_WRITEDATA[7];
		end
		if (!SYS_RST && AVS_WRITE && wait_r && AVS_ADDRESS == A_CTRL && AVS_BYTEENABLE[1])
			secondary_osc_enable_r <= AVS_WRITEDATA[8];
	end

	//--------------------------------------------------------------
	// Mode sequencer
	//--------------------------------------------------------------
	typedef enum logic [2:0] {S_RUN, S_SWITCH, S_IDLE, S_SLEEP, S_WAKE, S_START}
		pmmc_state_t;

	pmmc_state_t           state_r;
	pmmc_clk_t             src_r;
	pmmc_clk_t             tgt_r;
	logic                  cpu_on_r;
	logic                  per_on_r;
	logic [PMMC_CNT_W-1:0] cnt_r;
	logic [PMMC_CNT_W-1:0] settle_r;
	logic                  stable_r;
	logic                  pri_flag_r;
	logic                  sec_flag_r;
	logic                  fast_on;
	logic                  ready_tgt;
	pmmc_clk_t             want;

	assign fast_on = (int_freq_select_r != '0) | int_low_src_select_r;
	assign want    = sel_src(clk_source_select_r);
	always_comb
	begin
		unique case (tgt_r)
			PMMC_CLK_PRI:  ready_tgt = PRI_READY;
			PMMC_CLK_SEC:  ready_tgt = SEC_RUNNING;
			PMMC_CLK_INT:  ready_tgt = 1'b1;
			PMMC_CLK_NONE: ready_tgt = 1'b0;
		endcase
	end

	// Fast osc settling; stays set while enabled, so a switch keeps it
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST || !fast_on)
			settle_r <= '0;
		else if (FAST_TICK && settle_r != PMMC_CNT_W'(SETTLE_DLY))
			settle_r <= settle_r + 1'b1;
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			state_r  <= S_RUN;
			src_r    <= PMMC_CLK_PRI;
			tgt_r    <= PMMC_CLK_PRI;
			cpu_on_r <= 1'b1;
			per_on_r <= 1'b1;
			cnt_r    <= '0;
		end
		else
		begin
			unique case (state_r)
				S_RUN:
				begin
					if (SLEEP_EXEC && idle_on_sleep_r)
					begin
						// Sleep ignored when secondary is selected without secondary osc enable
						if (!(want == PMMC_CLK_SEC && !secondary_osc_enable_r))
						begin
							cpu_on_r <= 1'b0;
							tgt_r    <= want;
							cnt_r    <= '0;
							state_r  <= (want == src_r) ? S_IDLE : S_SWITCH;
						end
					end
					else if (SLEEP_EXEC)
					begin
						cpu_on_r <= 1'b0;
						per_on_r <= 1'b0;
						src_r    <= PMMC_CLK_NONE;
						state_r  <= S_SLEEP;
					end
					else if (want != src_r &&
						!(want == PMMC_CLK_SEC && !secondary_osc_enable_r))
					begin
						tgt_r   <= want;
						cnt_r   <= '0;
						state_r <= S_SWITCH;
					end
				end
				S_SWITCH:
				begin
					// Old source clocks on until new one is ready; peripherals held off while a secondary target is not ready
					if (!ready_tgt)
					begin
						cnt_r    <= '0;
						per_on_r <= (tgt_r != PMMC_CLK_SEC);
					end
					else if (OLD_TICK || FAST_TICK)
						cnt_r <= cnt_r + 1'b1;
					if (ready_tgt && cnt_r == PMMC_CNT_W'(PMMC_OLD_CYC + PMMC_NEW_CYC))
					begin
						src_r    <= tgt_r;
						per_on_r <= 1'b1;
						state_r  <= cpu_on_r ? S_RUN : S_IDLE;
					end
				end
				S_IDLE:
				begin
					if (WAKE_IRQ || WAKE_WDT)
					begin
						cnt_r <= '0;
						if (WAKE_WDT && want != src_r)
						begin
							tgt_r   <= want;
							state_r <= S_WAKE;
						end
						else
							state_r <= S_START;
					end
				end
				S_SLEEP:
				begin
					if (WAKE_IRQ || WAKE_WDT)
					begin
						cnt_r <= '0;
						tgt_r <= (STAGED_EN || FSCM_EN) ? PMMC_CLK_INT : want;
						state_r <= S_WAKE;
					end
				end
				S_WAKE:
				begin
					if (ready_tgt)                      // CPU clock withheld; peripheral clock too when woken from sleep
					begin
						src_r    <= tgt_r;
						per_on_r <= 1'b1;
						state_r  <= S_START;
					end
				end
				S_START:
				begin
					if (cnt_r == PMMC_CNT_W'(START_DLY))
					begin
						cpu_on_r <= 1'b1;
						state_r  <= (src_r != want) ? S_SWITCH : S_RUN;
						tgt_r    <= want;
						cnt_r    <= '0;
					end
					else
						cnt_r <= cnt_r + 1'b1;
				end
				default: state_r <= S_RUN;
			endcase
		end
	end

	//--------------------------------------------------------------
	// Status flags and oscillator enables
	//--------------------------------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			pri_flag_r <= 1'b1;
			sec_flag_r <= 1'b0;
			stable_r   <= 1'b0;
		end
		else if (state_r == S_SLEEP)
		begin
			pri_flag_r <= 1'b0;
			sec_flag_r <= 1'b0;
			stable_r   <= 1'b0;
		end
		else
		begin
			// Primary and secondary flags follow the source actually clocking
			pri_flag_r <= (src_r == PMMC_CLK_PRI);
			sec_flag_r <= (src_r == PMMC_CLK_SEC);
			stable_r   <= fast_on && settle_r == PMMC_CNT_W'(SETTLE_DLY) &&
				(src_r == PMMC_CLK_INT || state_r == S_SWITCH);
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			GATES <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
			FLAGS <= '0;
			CLK_SRC <= PMMC_CLK_PRI;
		end
		else
		begin
			GATES.cpu_clk_en  <= cpu_on_r && per_on_r;
			GATES.per_clk_en  <= per_on_r;
			// Primary off once internal or secondary drives, unless primary is the target
			GATES.pri_osc_en  <= (src_r == PMMC_CLK_PRI) || (tgt_r == PMMC_CLK_PRI &&
				state_r != S_SLEEP);
			GATES.sec_osc_on  <= secondary_osc_enable_r;
			GATES.fast_osc_en <= fast_on && state_r != S_SLEEP;
			// Slow osc kept for watchdog or monitor
			GATES.slow_osc_en <= WDT_EN || FSCM_EN ||
				(src_r == PMMC_CLK_INT && !fast_on);
			FLAGS   <= '{pri_flag_r, stable_r, sec_flag_r};
			CLK_SRC <= src_r;
		end
	end

	// Read mux; unmapped words read zero
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			AVS_READDATA <= '0;
		else if (AVS_READ && !wait_r)
		begin
			unique case (AVS_ADDRESS)
				A_CTRL:  AVS_READDATA <= {23'h0, secondary_osc_enable_r,
					int_low_src_select_r, int_freq_select_r, 1'b0,
					idle_on_sleep_r, clk_source_select_r};
				A_STAT:  AVS_READDATA <= {24'h0, state_r, src_r,
					pri_flag_r, stable_r, sec_flag_r};
				default: AVS_READDATA <= '0;
			endcase
		end
	end
endmodule
